// [inc/status_flags_pkg.sv]
// status word package: bit positions, reset values, timing constants and carrier structs
// assumes a single 125 MHz core clock with synchronous active-high reset
`default_nettype none
package status_flags_pkg;

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_MAIL_OUT  = 0;
  localparam int unsigned BIT_RST1      = 1;
  localparam int unsigned BIT_DONE1     = 2;
  localparam int unsigned BIT_DONE2     = 3;
  localparam int unsigned BIT_MSG1      = 4;
  localparam int unsigned BIT_MSG2      = 5;
  localparam int unsigned BIT_WAKE1     = 6;
  localparam int unsigned BIT_WAKE2     = 7;
  localparam int unsigned BIT_MAIL_IN   = 8;
  localparam int unsigned BIT_RST2      = 9;
  localparam int unsigned BIT_SOF1      = 10;
  localparam int unsigned BIT_SOF2      = 12;
  localparam int unsigned BIT_ID        = 14;
  localparam int unsigned BIT_VBUS      = 15;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned NUM_EVT       = 8;   // routed engine events
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [7:0]  RESET_EVT     = 8'h00;

  // ----------------------------------------------------------------
  // timing: host must wait this long after vbus on (other party)
  // ----------------------------------------------------------------
  localparam int unsigned VBUS_SETTLE_NS   = 10000;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned VBUS_SETTLE_CYC  = (VBUS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES      = 3;

  // ----------------------------------------------------------------
  // carrier structs
  // ----------------------------------------------------------------
  // engine events in order: done1,done2,rst1,rst2,wake1,wake2,sof1,sof2
  typedef struct packed {
    logic [NUM_EVT-1:0] set;     // one-cycle event pulses from the engines
    logic [NUM_EVT-1:0] clear;   // service clear from cpu or host
    logic [NUM_EVT-1:0] route;   // routing-to-host enable bits
  } evt_s;

  typedef struct packed {
    logic msg1Write;   // cpu wrote engine-1 message register
    logic msg2Write;   // cpu wrote engine-2 message register
    logic mailCpuWr;   // cpu wrote shared mailbox
    logic mailCpuRd;   // cpu read shared mailbox
    logic mailHostWr;  // host wrote shared mailbox
    logic mailHostRd;  // host read shared mailbox
  } mbox_s;

endpackage : status_flags_pkg
`default_nettype wire

// [hdl/pin_sync.sv]
// three-stage pin synchroniser with agreement filter
// assumes input is asynchronous to ref_clk
`default_nettype none
module pin_sync
  import status_flags_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pinAsync,
  output logic      pinLevel
);

  // ----------------------------------------------------------------
  // sync chain
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] stage_r;    // stage 0 feeds only stage 1
  logic [SYNC_STAGES-1:0] stage_nxt;
  logic                   level_r;    // filtered level
  logic                   level_nxt;

  // next values: change accepted when stages 1 and 2 agree
  always_comb
  begin
    stage_nxt = {stage_r[SYNC_STAGES-2:0], pinAsync};
    level_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : level_r;
  end

  // registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      stage_r <= '0;
      level_r <= 1'b0;
    end
    else
    begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

  assign pinLevel = level_r;

endmodule : pin_sync
`default_nettype wire

// [hdl/host_port_status_flags.sv]
// host port status word: mailbox, message and routed engine event flags
// assumes engine events are one-cycle pulses on ref_clk; vbus and id come from pins
// Behaviour
// R01 - word reachable only from host port
// R02 - host status read starts no memory cycle
// R03 - bit 15 follows vbus comparator
// R04 - host waits 10 us after vbus on
// R05 - bit 14 follows otg id pin
// R06 - bits 12,10 report sof/eop events
// R07 - bits 9,1 report bus reset events
// R08 - bits 7,6 report resume events
// R09 - bit 8 set by host, cleared cpu read
// R10 - bit 0 set by cpu, cleared host read
// R11 - bits 5,4 set by message write
// R12 - bit 3 engine 2 done or endpoint
// R13 - bit 2 engine 1 done or endpoint
// R14 - bits 13,11 always read zero
// R15 - event flags shown only when routed
// R16 - message write raises host irq
// R17 - mailbox cpu write raises, host read drops irq
// R18 - routing bit steers event to host
`default_nettype none
module host_port_status_flags
  import status_flags_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        vbusAbove,      // comparator, async
  input  wire logic        otgIdPin,       // id pin, async
  input  wire evt_s        evt,            // engine events, routing, clears
  input  wire mbox_s       mbox,           // mailbox and message accesses
  input  wire logic        statusRead,     // host port read strobe of status word
  output logic [WORD_W-1:0] statusWord,    // registered status word to host port
  output logic             host_port_irq   // host port interrupt
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic vbusLevel;   // filtered vbus comparator
  logic idLevel;     // filtered id pin

  pin_sync u_vbus (.ref_clk(ref_clk), .reset(reset), .pinAsync(vbusAbove), .pinLevel(vbusLevel));
  pin_sync u_id   (.ref_clk(ref_clk), .reset(reset), .pinAsync(otgIdPin),  .pinLevel(idLevel));

  // ----------------------------------------------------------------
  // flag state
  // ----------------------------------------------------------------
  logic [NUM_EVT-1:0] evt_r;       // sticky engine event flags
  logic [NUM_EVT-1:0] evt_nxt;
  logic               msg1_r;      // engine1_message_flag
  logic               msg1_nxt;
  logic               msg2_r;      // engine2_message_flag
  logic               msg2_nxt;
  logic               mailIn_r;    // incoming mailbox flag
  logic               mailIn_nxt;
  logic               mailOut_r;   // outgoing mailbox flag
  logic               mailOut_nxt;
  logic [WORD_W-1:0]  word_r;      // registered status word
  logic [WORD_W-1:0]  word_nxt;
  logic [NUM_EVT-1:0] shown;       // routed view of engine flags

  // next values: a set wins over a clear in the same cycle, for engine events only when routed
  always_comb
  begin
    // only routed events latch; unrouted ones belong to the cpu path
    evt_nxt     = (evt_r & ~evt.clear) | (evt.set & evt.route);          // R15 R18
    // message flags drop on a status read; there is no cpu-side clear
    msg1_nxt    = mbox.msg1Write | (msg1_r & ~statusRead);               // R11 R16
    msg2_nxt    = mbox.msg2Write | (msg2_r & ~statusRead);               // R11 R16
    mailIn_nxt  = mbox.mailHostWr | (mailIn_r & ~mbox.mailCpuRd);        // R09
    mailOut_nxt = mbox.mailCpuWr | (mailOut_r & ~mbox.mailHostRd);       // R10 R17
  end

  // status word assembly from current flags
  always_comb
  begin
    shown                 = evt_r & evt.route;                           // R15
    word_nxt              = RESET_WORD;                                  // R14
    word_nxt[BIT_VBUS]    = vbusLevel;                                   // R03
    word_nxt[BIT_ID]      = idLevel;                                     // R05
    word_nxt[BIT_DONE1]   = shown[0];                                    // R13
    word_nxt[BIT_DONE2]   = shown[1];                                    // R12
    word_nxt[BIT_RST1]    = shown[2];                                    // R07
    word_nxt[BIT_RST2]    = shown[3];                                    // R07
    word_nxt[BIT_WAKE1]   = shown[4];                                    // R08
    word_nxt[BIT_WAKE2]   = shown[5];                                    // R08
    word_nxt[BIT_SOF1]    = shown[6];                                    // R06
    word_nxt[BIT_SOF2]    = shown[7];                                    // R06
    word_nxt[BIT_MSG1]    = msg1_r;                                      // R11
    word_nxt[BIT_MSG2]    = msg2_r;                                      // R11
    word_nxt[BIT_MAIL_IN] = mailIn_r;                                    // R09
    word_nxt[BIT_MAIL_OUT]= mailOut_r;                                   // R10
  end

  // registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      evt_r     <= RESET_EVT;
      msg1_r    <= 1'b0;
      msg2_r    <= 1'b0;
      mailIn_r  <= 1'b0;
      mailOut_r <= 1'b0;
      word_r    <= RESET_WORD;
    end
    else
    begin
      evt_r     <= evt_nxt;
      msg1_r    <= msg1_nxt;
      msg2_r    <= msg2_nxt;
      mailIn_r  <= mailIn_nxt;
      mailOut_r <= mailOut_nxt;
      word_r    <= word_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the word is a pure register view: no memory cycle, no cpu port exists
  assign statusWord    = word_r;                                         // R01 R02
  // irq from routed events, message flags and outgoing mailbox
  assign host_port_irq = (|shown) | msg1_r | msg2_r | mailOut_r;         // R16 R17 R18

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_msgWrite;
    mbox.msg1Write;
  endsequence

  property p_msgSets;
    @(posedge ref_clk) disable iff (reset)
      s_msgWrite |=> msg1_r ##1 statusWord[BIT_MSG1];
  endproperty
  a_msgSets: assert property (p_msgSets) else $error("message flag not set"); // R11

  property p_msgIrq;
    @(posedge ref_clk) disable iff (reset) mbox.msg2Write |=> host_port_irq;
  endproperty
  a_msgIrq: assert property (p_msgIrq) else $error("message write gave no irq"); // R16

  property p_msgClear;
    @(posedge ref_clk) disable iff (reset)
      (statusRead && !mbox.msg1Write) |=> !msg1_r;
  endproperty
  a_msgClear: assert property (p_msgClear) else $error("message flag not cleared"); // R11

  property p_mailOut;
    @(posedge ref_clk) disable iff (reset)
      mbox.mailCpuWr |=> host_port_irq ##1 statusWord[BIT_MAIL_OUT];
  endproperty
  a_mailOut: assert property (p_mailOut) else $error("mailbox out not raised"); // R17

  property p_mailOutClr;
    @(posedge ref_clk) disable iff (reset)
      (mbox.mailHostRd && !mbox.mailCpuWr) |=> !mailOut_r;
  endproperty
  a_mailOutClr: assert property (p_mailOutClr) else $error("mailbox out not cleared"); // R10

  property p_mailIn;
    @(posedge ref_clk) disable iff (reset)
      mbox.mailHostWr |=> mailIn_r ##1 statusWord[BIT_MAIL_IN];
  endproperty
  a_mailIn: assert property (p_mailIn) else $error("mailbox in not set"); // R09

  property p_mailInClr;
    @(posedge ref_clk) disable iff (reset)
      (mbox.mailCpuRd && !mbox.mailHostWr) |=> !mailIn_r;
  endproperty
  a_mailInClr: assert property (p_mailInClr) else $error("mailbox in not cleared"); // R09

  property p_reserved;
    @(posedge ref_clk) disable iff (reset) !statusWord[13] && !statusWord[11];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit nonzero"); // R14

  property p_unrouted;
    @(posedge ref_clk) disable iff (reset)
      !evt.route[1] |=> !statusWord[BIT_DONE2] || $past(evt.route[1], 1) == 1'b1;
  endproperty
  a_unrouted: assert property (p_unrouted) else $error("unrouted event shown"); // R15

  property p_routedDone;
    @(posedge ref_clk) disable iff (reset)
      (evt.set[0] && evt.route[0]) ##1 evt.route[0] |-> host_port_irq;
  endproperty
  a_routedDone: assert property (p_routedDone) else $error("routed event gave no irq"); // R18

  property p_vbus;
    @(posedge ref_clk) disable iff (reset) vbusLevel |=> statusWord[BIT_VBUS];
  endproperty
  a_vbus: assert property (p_vbus) else $error("vbus bit mismatch"); // R03

  property p_id;
    @(posedge ref_clk) disable iff (reset) !idLevel |=> !statusWord[BIT_ID];
  endproperty
  a_id: assert property (p_id) else $error("id bit mismatch"); // R05

  property p_vbusLow;
    @(posedge ref_clk) disable iff (reset) !vbusLevel |=> !statusWord[BIT_VBUS];
  endproperty
  a_vbusLow: assert property (p_vbusLow) else $error("vbus bit stuck high"); // R03

  property p_idHigh;
    @(posedge ref_clk) disable iff (reset) idLevel |=> statusWord[BIT_ID];
  endproperty
  a_idHigh: assert property (p_idHigh) else $error("id bit stuck low"); // R05

  // ----------------------------------------------------------------
  // assertions on the routed event vector
  // ----------------------------------------------------------------
  // a routed pulse must latch, whatever the clear says in that cycle
  property p_evtSet;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> ((evt_r & $past(evt.set) & $past(evt.route)) == ($past(evt.set) & $past(evt.route)));
  endproperty
  a_evtSet: assert property (p_evtSet) else $error("routed event not latched"); // R18

  // a clear with no competing set must empty the flag
  property p_evtClear;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> ((evt_r & $past(evt.clear) & ~$past(evt.set)) == '0);
  endproperty
  a_evtClear: assert property (p_evtClear) else $error("event flag not cleared"); // R15

  // a routed pulse that stays routed one more cycle reaches the word
  sequence s_sof2Routed;
    (evt.set[7] && evt.route[7]) ##1 evt.route[7];
  endsequence

  property p_sof2Word;
    @(posedge ref_clk) disable iff (reset) s_sof2Routed |=> statusWord[BIT_SOF2];
  endproperty
  a_sof2Word: assert property (p_sof2Word) else $error("sof flag not shown"); // R06

  sequence s_rst1Routed;
    (evt.set[2] && evt.route[2]) ##1 evt.route[2];
  endsequence

  property p_rst1Word;
    @(posedge ref_clk) disable iff (reset) s_rst1Routed |=> statusWord[BIT_RST1];
  endproperty
  a_rst1Word: assert property (p_rst1Word) else $error("bus reset flag not shown"); // R07

  sequence s_wake2Routed;
    (evt.set[5] && evt.route[5]) ##1 evt.route[5];
  endsequence

  property p_wake2Word;
    @(posedge ref_clk) disable iff (reset) s_wake2Routed |=> statusWord[BIT_WAKE2];
  endproperty
  a_wake2Word: assert property (p_wake2Word) else $error("wake flag not shown"); // R08

endmodule : host_port_status_flags
`default_nettype wire

// [verif/host_reader_model.sv]
// host side model: strobes status reads and keeps the vbus settle wait
// assumes ref_clk and the sync active-high reset are shared with the block
`default_nettype none
module host_reader_model
  import status_flags_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              pollReq,     // bench asks for one status read
  input  wire logic              vbusAbove,   // supply state as the host sees it
  input  wire logic [WORD_W-1:0] statusWord,  // word presented by the block
  output logic                   statusRead,  // one-cycle read strobe
  output logic [WORD_W-1:0]      readWord,    // word taken at the read
  output logic                   vbusSettled  // vbus bit may now be trusted
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned settleCnt;  // cycles since the supply came up

  // ----------------------------------------------------------------
  // read strobe, captured word and settle count
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    statusRead <= pollReq & ~reset;
    if (reset)
    begin
      readWord <= RESET_WORD;
    end
    else if (statusRead)
    begin
      readWord <= statusWord;  // taken at the edge the read lands
    end
    // a dropped supply restarts the wait, never trust a stale level
    if (reset || !vbusAbove)
    begin
      settleCnt <= 0;
    end
    else if (settleCnt < VBUS_SETTLE_CYC)
    begin
      settleCnt <= settleCnt + 1;
    end
  end
  assign vbusSettled = (settleCnt >= VBUS_SETTLE_CYC);
endmodule : host_reader_model
`default_nettype wire

// [verif/host_port_status_flags_tb_top.sv]
// bench for the host port status word: table of routed events, then hand cases
// assumes the design package and a host model that issues status reads
`default_nettype none
module host_port_status_flags_tb_top
  import status_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, reset, vbusAbove, otgIdPin, statusRead, pollReq, host_port_irq, vbusSettled;
  evt_s        evt;         // engine pulses, clears, routing
  mbox_s       mbox;        // mailbox and message accesses
  logic [15:0] statusWord, readWord;
  int          error_cnt, checks;
  // expected word per event index: done1,done2,rst1,rst2,wake1,wake2,sof1,sof2
  logic [15:0] rowWord [8] = '{16'h0004, 16'h0008, 16'h0002, 16'h0200,
                               16'h0040, 16'h0080, 16'h0400, 16'h1000};

  host_port_status_flags DUT (.ref_clk(ref_clk), .reset(reset), .vbusAbove(vbusAbove), .otgIdPin(otgIdPin),
    .evt(evt), .mbox(mbox), .statusRead(statusRead), .statusWord(statusWord), .host_port_irq(host_port_irq));
  host_reader_model host (.ref_clk(ref_clk), .reset(reset), .pollReq(pollReq), .vbusAbove(vbusAbove),
    .statusWord(statusWord), .statusRead(statusRead), .readWord(readWord), .vbusSettled(vbusSettled));

  // ----------------------------------------------------------------
  // clock, watchdog and closing report
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // drivers and compare; flags need two edges, so wait four to be settled
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] expW, input logic expI);
    repeat (4) @(posedge ref_clk);
    #1;
    checks++;
    if (statusWord !== expW || host_port_irq !== expI)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h/%b seen %h/%b", what, expW, expI, statusWord, host_port_irq);
    end
  endtask : chk
  task automatic evtPulse(input logic [7:0] s, input logic [7:0] c);
    @(posedge ref_clk);
    evt.set   <= s;
    evt.clear <= c;
    @(posedge ref_clk);
    evt.set   <= 8'h00;
    evt.clear <= 8'h00;
  endtask : evtPulse
  task automatic mboxPulse(input mbox_s m);
    @(posedge ref_clk);
    mbox <= m;
    @(posedge ref_clk);
    mbox <= '0;
  endtask : mboxPulse
  task automatic hostRead();
    @(posedge ref_clk);
    pollReq <= 1'b1;
    @(posedge ref_clk);
    pollReq <= 1'b0;
  endtask : hostRead

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1; vbusAbove = 1'b0; otgIdPin = 1'b0; evt = '0; mbox = '0; pollReq = 1'b0;
    error_cnt = 0; checks = 0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    evt.route <= 8'hFF;
    chk("reset word", 16'h0000, 1'b0);
    // each routed event sets its own bit and the irq, its clear drops both
    for (int i = 0; i < 8; i++)
    begin
      evtPulse(8'h01 << i, 8'h00);
      chk("event flag", rowWord[i], 1'b1);
      evtPulse(8'h00, 8'h01 << i);
      chk("event clear", 16'h0000, 1'b0);
    end
    // unrouted event is not taken, routed one can be hidden and shown again
    @(posedge ref_clk) evt.route <= 8'hFE;
    evtPulse(8'h01, 8'h00);
    chk("unrouted event", 16'h0000, 1'b0);
    @(posedge ref_clk) evt.route <= 8'hFF;
    evtPulse(8'h02, 8'h00);
    @(posedge ref_clk) evt.route <= 8'hFD;
    chk("hidden flag", 16'h0000, 1'b0);
    @(posedge ref_clk) evt.route <= 8'hFF;
    evtPulse(8'h01, 8'h01);
    chk("set beats clear", 16'h000C, 1'b1);
    evtPulse(8'h00, 8'h03);
    // both message flags at once, one status read clears them
    mboxPulse('{msg1Write: 1'b1, msg2Write: 1'b1, default: 1'b0});
    chk("message flags", 16'h0030, 1'b1);
    hostRead();
    chk("message cleared", 16'h0000, 1'b0);
    checks++;
    if (readWord !== 16'h0030)
    begin
      error_cnt++;
      $display("MISMATCH read word expected 0030 seen %h", readWord);
    end
    // outgoing mailbox survives a status read, host mailbox read clears it
    mboxPulse('{mailCpuWr: 1'b1, default: 1'b0});
    chk("mail out", 16'h0001, 1'b1);
    hostRead();
    chk("mail out after status read", 16'h0001, 1'b1);
    mboxPulse('{mailHostRd: 1'b1, default: 1'b0});
    chk("mail out cleared", 16'h0000, 1'b0);
    mboxPulse('{mailHostWr: 1'b1, default: 1'b0});
    chk("mail in", 16'h0100, 1'b0);
    mboxPulse('{mailCpuRd: 1'b1, default: 1'b0});
    chk("mail in cleared", 16'h0000, 1'b0);
    // pins: read only once the host's settle wait has run out
    @(posedge ref_clk);
    vbusAbove <= 1'b1;
    otgIdPin  <= 1'b1;
    for (int n = 0; n < 2000 && vbusSettled !== 1'b1; n++) @(posedge ref_clk);
    if (vbusSettled !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
    chk("vbus and id high", 16'hC000, 1'b0);
    @(posedge ref_clk) vbusAbove <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("vbus low", 16'h4000, 1'b0);
    @(posedge ref_clk) otgIdPin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("id low", 16'h0000, 1'b0);
    // mid-run reset drops every flag, then a fresh write still lands
    mboxPulse('{msg1Write: 1'b1, mailCpuWr: 1'b1, mailHostWr: 1'b1, default: 1'b0});
    evtPulse(8'h80, 8'h00);
    @(posedge ref_clk) reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    chk("mid-run reset", 16'h0000, 1'b0);
    mboxPulse('{msg2Write: 1'b1, default: 1'b0});
    chk("write after reset", 16'h0020, 1'b1);
    wrap_up();
  end
endmodule : host_port_status_flags_tb_top
`default_nettype wire
